/* File: design/tjcfg_los.sv */
/*
 * Loss-of-signal detector and recovery checker working on received bits.
 * Assumes bit_stb and mark are already in the hclk domain.
 */
`timescale 1ns/10ps
module tjcfg_los (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic bit_stb,
	input wire logic mark,
	input wire logic [7:0] detect_count,
	input wire logic [7:0] recovery_count,
	input wire logic density_en,
	input wire logic restart,
	output logic los_q,
	output logic los_set_q,
	output logic los_clr_q
);
	typedef struct packed {
		logic los;
		logic set;
		logic clr;
		logic [12:0] zeros;
		logic [12:0] win;
		logic [8:0] ones;
		logic dens_fail;
	} tjcfg_los_t;

	tjcfg_los_t q, d;
	logic [12:0] thr;
	logic [8:0] need;

	// Interval is 16 bits per count step: 0a gives 176
	assign thr = 13'((detect_count + 13'h1) * tjcfg_pkg::LOS_BLOCK_BITS);
	// 15 gives 22 ones
	assign need = 9'(recovery_count) + 9'h1;

	always_comb begin
		d = q;
		d.set = 1'b0;
		d.clr = 1'b0;
		if (restart) begin
			d = '0;
		end else if (bit_stb) begin
			if (mark) begin
				d.zeros = '0;
			end else if (q.zeros != 13'h1fff) begin
				d.zeros = q.zeros + 13'h1;
			end
			if (!q.los) begin
				if (d.zeros >= thr) begin
					d.los = 1'b1;
					d.set = 1'b1;
					d.win = '0;
					d.ones = '0;
					d.dens_fail = 1'b0;
				end
			end else begin
				d.win = q.win + 13'h1;
				if (mark) begin
					d.ones = q.ones + 9'h1;
				end
				if (d.zeros >= tjcfg_pkg::LOS_DENSITY_RUN) begin
					d.dens_fail = 1'b1;
				end
				if (d.ones >= need &&
					!(density_en && d.dens_fail)) begin
					d.los = 1'b0;
					d.clr = 1'b1;
				end else if (d.win >= thr) begin
					// New interval: earlier ones no longer count
					d.win = '0;
					d.ones = '0;
					d.dens_fail = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign los_q = q.los;
	assign los_set_q = q.set;
	assign los_clr_q = q.clr;

	sequence s_zero;
		bit_stb && !mark;
	endsequence

	AST_ZERO_RESTART: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && bit_stb && mark && !restart |=> q.zeros == 13'h0)
		else $error("zero run not cleared by a mark");
	AST_LOS_DECLARE: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && !q.los && !restart && q.zeros + 13'h1 >= thr) ##0 s_zero
		|=> q.los && q.set)
		else $error("loss of signal not declared at threshold");
	AST_LOS_EARLY: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(q.los) |-> q.zeros >= thr)
		else $error("loss of signal declared too early");
	AST_LOS_RECOVER: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(q.los) && !$past(restart) |-> q.ones >= need && q.clr)
		else $error("recovery without enough ones");
	AST_DENSITY: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(q.los) && density_en && !$past(restart) |-> !q.dens_fail)
		else $error("recovery despite 15 zero run");
endmodule : tjcfg_los

/* File: design/tjcfg_top.sv */
/*
 * T1/J1 start-up configuration registers with loss-of-signal supervision,
 * reached over an AHB-Lite slave port.
 * Assumes one AHB master, word transfers only, line pins asynchronous.
 */
`timescale 1ns/10ps
module tjcfg_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic line_bit_stb,
	input wire logic line_mark,
	output logic t1_mode_q,
	output logic j1_mode_q,
	output logic e1_mode_q,
	output logic [2:0] line_code_q,
	output logic digital_if_q,
	output logic single_rail_q,
	output logic [7:0] clock_gen_q,
	output logic los_q,
	output logic alarm_irq_q
);
	typedef struct packed {
		logic [1:0] mode;
		logic [4:0] line_code;
		logic [7:0] detect;
		logic [7:0] recovery;
		logic [1:0] los_ctrl;
		logic [7:0] mask;
		logic [7:0] clk_gen;
		logic restart;
		logic wr_pend;
		logic rd_pend;
		logic [7:0] addr;
		logic ready;
		logic [31:0] rdata;
		logic stb_s1;
		logic stb_s2;
		logic stb_s3;
		logic mark_s1;
		logic mark_s2;
		logic irq;
		logic e1;
		logic t1;
		logic j1;
		logic [2:0] code;
	} tjcfg_st_t;

	tjcfg_st_t q, d;
	logic los, los_set, los_clr;
	logic take;

	// ------------------------------------------------------------
	// Register read mux
	// ------------------------------------------------------------
	function automatic logic [31:0] rd_word(input tjcfg_st_t s,
		input logic l);
		unique case (s.addr)
		tjcfg_pkg::OFS_MODE: rd_word = {30'h0, s.mode};
		tjcfg_pkg::OFS_LINE_CODE: rd_word = {27'h0, s.line_code};
		tjcfg_pkg::OFS_LOS_DETECT: rd_word = {24'h0, s.detect};
		tjcfg_pkg::OFS_LOS_RECOVERY: rd_word = {24'h0, s.recovery};
		tjcfg_pkg::OFS_LOS_CTRL: rd_word = {30'h0, s.los_ctrl};
		tjcfg_pkg::OFS_INT_MASK: rd_word = {24'h0, s.mask};
		tjcfg_pkg::OFS_CLOCK_GEN: rd_word = {24'h0, s.clk_gen};
		tjcfg_pkg::OFS_STATUS: rd_word = {31'h0, l};
		// Command and unused addresses read as zero
		default: rd_word = 32'h0000_0000;
		endcase
	endfunction : rd_word

	assign take = hsel && htrans[1] && hready;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		d.restart = 1'b0;
		d.irq = 1'b0;
		d.stb_s1 = line_bit_stb;
		d.stb_s2 = q.stb_s1;
		d.stb_s3 = q.stb_s2;
		d.mark_s1 = line_mark;
		d.mark_s2 = q.mark_s1;
		d.wr_pend = 1'b0;
		d.rd_pend = 1'b0;
		d.ready = 1'b1;
		// Write data phase; every control register stores what is written
		if (q.wr_pend) begin
			unique case (q.addr)
			tjcfg_pkg::OFS_MODE: d.mode = hwdata[1:0];
			tjcfg_pkg::OFS_LINE_CODE: begin
				d.line_code = hwdata[4:0];
			end
			tjcfg_pkg::OFS_LOS_DETECT: d.detect = hwdata[7:0];
			tjcfg_pkg::OFS_LOS_RECOVERY: d.recovery = hwdata[7:0];
			tjcfg_pkg::OFS_LOS_CTRL: d.los_ctrl = hwdata[1:0];
			tjcfg_pkg::OFS_INT_MASK: d.mask = hwdata[7:0];
			tjcfg_pkg::OFS_CLOCK_GEN: d.clk_gen = hwdata[7:0];
			tjcfg_pkg::OFS_COMMAND: begin
				d.restart = hwdata[tjcfg_pkg::CMD_LOS_RESTART_BIT];
			end
			// Status and unused addresses ignore writes
			default: d.restart = 1'b0;
			endcase
		end
		// Decodes follow the next register value, so pins change with it
		d.e1 = !d.mode[tjcfg_pkg::MODE_PCM_BIT];
		d.t1 = d.mode[tjcfg_pkg::MODE_PCM_BIT] &&
			!d.mode[tjcfg_pkg::MODE_JAPAN_BIT];
		d.j1 = d.mode[tjcfg_pkg::MODE_PCM_BIT] &&
			d.mode[tjcfg_pkg::MODE_JAPAN_BIT];
		// An unsupported code falls back to plain AMI rather than misencode
		d.code = tjcfg_pkg::code_ok(d.line_code[2:0],
			d.line_code[tjcfg_pkg::LC_DIGITAL_BIT]) ?
			d.line_code[2:0] : 3'(tjcfg_pkg::TJCFG_AMI);
		// A read waits one cycle so a write just before it is seen
		if (q.rd_pend) begin
			d.rdata = rd_word(q, los);
		end
		if (take) begin
			d.addr = haddr[7:0];
			d.wr_pend = hwrite;
			d.rd_pend = !hwrite;
			d.ready = hwrite;
		end
		// Clearing alarms interrupt only with the recovery option set
		d.irq = (los_set && !q.mask[tjcfg_pkg::MASK_LOS_SET_BIT]) ||
			(los_clr && q.los_ctrl[tjcfg_pkg::LOSC_RECOV_INT_BIT] &&
			!q.mask[tjcfg_pkg::MASK_LOS_CLR_BIT]);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
			q.mode <= tjcfg_pkg::RST_MODE;
			q.line_code <= tjcfg_pkg::RST_LINE_CODE;
			q.detect <= tjcfg_pkg::RST_LOS_DETECT;
			q.recovery <= tjcfg_pkg::RST_LOS_RECOVERY;
			q.los_ctrl <= tjcfg_pkg::RST_LOS_CTRL;
			q.mask <= tjcfg_pkg::RST_INT_MASK;
			q.clk_gen <= tjcfg_pkg::RST_CLOCK_GEN;
			q.ready <= 1'b1;
			q.e1 <= !tjcfg_pkg::RST_MODE[tjcfg_pkg::MODE_PCM_BIT];
		end else if (ce) begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// Loss-of-signal supervision
	// ------------------------------------------------------------
	tjcfg_los u_los (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.bit_stb(q.stb_s2 && !q.stb_s3),
		.mark(q.mark_s2),
		.detect_count(q.detect),
		.recovery_count(q.recovery),
		.density_en(q.los_ctrl[tjcfg_pkg::LOSC_DENSITY_BIT]),
		.restart(q.restart),
		.los_q(los),
		.los_set_q(los_set),
		.los_clr_q(los_clr)
	);

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign hrdata = q.rdata;
	assign hreadyout = q.ready;
	assign hresp = 1'b0;
	assign e1_mode_q = q.e1;
	assign t1_mode_q = q.t1;
	assign j1_mode_q = q.j1;
	assign line_code_q = q.code;
	assign digital_if_q = q.line_code[tjcfg_pkg::LC_DIGITAL_BIT];
	assign single_rail_q = q.line_code[tjcfg_pkg::LC_SINGLE_RAIL_BIT];
	assign clock_gen_q = q.clk_gen;
	assign los_q = los;
	assign alarm_irq_q = q.irq;

	sequence s_wr(logic [7:0] a);
		take && hwrite && haddr[7:0] == a && ce;
	endsequence

	AST_E1_WHEN_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
		e1_mode_q == !(t1_mode_q || j1_mode_q))
		else $error("E1 and T1/J1 modes not exclusive");
	AST_J1_SELECT: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wr(tjcfg_pkg::OFS_MODE) ##1 ce && hwdata[1:0] == 2'h3 |=>
		j1_mode_q && !t1_mode_q)
		else $error("J1 not selected");
	AST_READ_BACK: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wr(tjcfg_pkg::OFS_LOS_DETECT) ##1 ce |=>
		q.detect == $past(hwdata[7:0]))
		else $error("written control value not held");
	AST_ANALOG_CODE: assert property (@(posedge hclk) disable iff (!hresetn)
		!digital_if_q |-> line_code_q <= 3'(tjcfg_pkg::TJCFG_B8ZS))
		else $error("analog interface given unsupported code");
	AST_NRZ_DIGITAL: assert property (@(posedge hclk) disable iff (!hresetn)
		digital_if_q && q.line_code[2:0] == 3'(tjcfg_pkg::TJCFG_NRZ) |->
		line_code_q == 3'(tjcfg_pkg::TJCFG_NRZ))
		else $error("digital interface lost NRZ");
	AST_CLEAR_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && los_clr && q.los_ctrl[1] && !q.mask[1] |=> alarm_irq_q)
		else $error("no interrupt on alarm clearing");
	AST_NO_CLEAR_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && los_clr && !los_set && !q.los_ctrl[1] |=> !alarm_irq_q)
		else $error("clearing interrupt without enable");
	AST_MASK_RESET: assert property (@(posedge hclk)
		$rose(hresetn) |-> q.mask == tjcfg_pkg::RST_INT_MASK)
		else $error("interrupt mask not ff after reset");
	AST_CLOCK_RESET: assert property (@(posedge hclk)
		$rose(hresetn) |-> clock_gen_q == tjcfg_pkg::CLK_FIXED_1544)
		else $error("clock generation not fixed mode after reset");
endmodule : tjcfg_top

/* File: inc/tjcfg_pkg.sv */
/*
 * Constants of the T1/J1 configuration and loss-of-signal block:
 * register offsets, reset values, field positions, line codes, LOS counts.
 * Assumes a 32-bit AHB-Lite bus with one aligned word per register.
 */
package tjcfg_pkg;
	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_LINE_CODE = 8'h04;
	localparam logic [7:0] OFS_LOS_DETECT = 8'h08;
	localparam logic [7:0] OFS_LOS_RECOVERY = 8'h0c;
	localparam logic [7:0] OFS_LOS_CTRL = 8'h10;
	localparam logic [7:0] OFS_INT_MASK = 8'h14;
	localparam logic [7:0] OFS_CLOCK_GEN = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;
	localparam logic [7:0] OFS_COMMAND = 8'h20;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int MODE_PCM_BIT = 0;
	localparam int MODE_JAPAN_BIT = 1;
	localparam int LC_DIGITAL_BIT = 3;
	localparam int LC_SINGLE_RAIL_BIT = 4;
	localparam int LOSC_DENSITY_BIT = 0;
	localparam int LOSC_RECOV_INT_BIT = 1;
	localparam int MASK_LOS_SET_BIT = 0;
	localparam int MASK_LOS_CLR_BIT = 1;
	localparam int CMD_LOS_RESTART_BIT = 0;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [1:0] RST_MODE = 2'h0;
	localparam logic [4:0] RST_LINE_CODE = 5'h00;
	localparam logic [7:0] RST_LOS_DETECT = 8'h00;
	localparam logic [7:0] RST_LOS_RECOVERY = 8'h00;
	localparam logic [1:0] RST_LOS_CTRL = 2'h0;
	localparam logic [7:0] RST_INT_MASK = 8'hff;
	localparam logic [7:0] RST_CLOCK_GEN = 8'h00;
	localparam logic [7:0] CLK_FIXED_1544 = 8'h00;

	// ------------------------------------------------------------
	// Line codes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		TJCFG_AMI = 3'h0,
		TJCFG_AMI_B7S = 3'h1,
		TJCFG_B8ZS = 3'h2,
		TJCFG_B8ZS_PRE = 3'h3,
		TJCFG_NRZ = 3'h4
	} tjcfg_code_t;

	// ------------------------------------------------------------
	// Loss-of-signal counts
	// ------------------------------------------------------------
	localparam logic [12:0] LOS_BLOCK_BITS = 13'h0010;
	localparam logic [12:0] LOS_DENSITY_RUN = 13'h000f;

	// Codes legal for the chosen interface; analog lacks precoding and NRZ
	function automatic logic code_ok(input logic [2:0] code,
		input logic digital);
		code_ok = (code <= 3'(TJCFG_B8ZS)) ||
			(digital && code <= 3'(TJCFG_NRZ));
	endfunction : code_ok
endpackage : tjcfg_pkg

/* File: test/t1j1_init_config_los_tb.sv */
/*
 * Self-checking bench: registers over AHB-Lite, mode and line-code outputs,
 * loss-of-signal detection, recovery, density check and alarm pulses.
 * Assumes the design answers writes with no wait and reads with one.
 */
`timescale 1ns/10ps
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module t1j1_init_config_los_tb;
	logic hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, d, v;
	logic [1:0] htrans;
	logic [2:0] hsize, line_code_q;
	logic [7:0] clock_gen_q, a;
	logic line_bit_stb, line_mark, t1_mode_q, j1_mode_q, e1_mode_q;
	logic digital_if_q, single_rail_q, los_q, alarm_irq_q;
	int n_errors = 0, n_compared = 0, irq_cnt = 0, seed, i, k;

	assign hready = hreadyout;

	tjcfg_top uut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp),
		.line_bit_stb(line_bit_stb), .line_mark(line_mark),
		.t1_mode_q(t1_mode_q), .j1_mode_q(j1_mode_q),
		.e1_mode_q(e1_mode_q), .line_code_q(line_code_q),
		.digital_if_q(digital_if_q), .single_rail_q(single_rail_q),
		.clock_gen_q(clock_gen_q), .los_q(los_q),
		.alarm_irq_q(alarm_irq_q));

	tjcfg_line_model line_src (.hclk(hclk), .line_bit_stb(line_bit_stb),
		.line_mark(line_mark));

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	always @(posedge hclk) if (alarm_irq_q === 1'b1) irq_cnt <= irq_cnt + 1;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : finish_test

	task automatic check(input string n, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : check

	task automatic wait_rdy();
		int j;
		j = 0;
		@(posedge hclk);
		while (hready !== 1'b1 && j < 40) begin
			@(posedge hclk);
			j++;
		end
		if (hready !== 1'b1) begin
			n_errors++;
			$display("CHECK FAILED hready expected 1 seen stuck");
			finish_test();
		end
	endtask : wait_rdy

	task automatic bus(input logic w, input logic [7:0] ad,
		input logic [31:0] wd, output logic [31:0] rdat);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h000000, ad};
		wait_rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		wait_rdy();
		rdat = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
		logic [31:0] x;
		bus(1'b1, ad, wd, x);
	endtask : wr

	task automatic rd(input logic [7:0] ad, output logic [31:0] rdat);
		bus(1'b0, ad, 32'h00000000, rdat);
	endtask : rd

	// Send bits, then give the synchroniser and detector time to settle
	task automatic line(input logic b, input int n);
		line_src.send(b, n);
		repeat (6) @(posedge hclk);
	endtask : line

	// Analog side: AMI, AMI with stuffing, B8ZS; digital adds the rest
	function automatic logic [2:0] exp_code(input logic [2:0] c,
		input logic dig);
		if (c <= 3'h2 || (dig && c <= 3'h4)) return c;
		return 3'h0;
	endfunction : exp_code

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 24414;
		hresetn = 1'b0;
		ce = 1'b1;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		haddr = 32'h00000000;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// Programming starts only after reset is released
		`CHK("e1_mode_q", 1'b1, e1_mode_q);
		`CHK("clock_gen_q", 8'h00, clock_gen_q);
		rd(tjcfg_pkg::OFS_INT_MASK, d);
		`CHK("int mask", 32'h000000ff, d);
		rd(tjcfg_pkg::OFS_CLOCK_GEN, d);
		`CHK("clock gen", 32'h00000000, d);
		$display("test reset done");

		for (i = 3; i >= 0; i--) begin
			wr(tjcfg_pkg::OFS_MODE, 32'(i));
			@(posedge hclk);
			`CHK("e1_mode_q", !i[0], e1_mode_q);
			`CHK("t1_mode_q", i[0] && !i[1], t1_mode_q);
			`CHK("j1_mode_q", i[0] && i[1], j1_mode_q);
			rd(tjcfg_pkg::OFS_MODE, d);
			`CHK("mode readback", i, d);
		end
		$display("test modes done");

		for (i = 0; i < 16; i++) begin
			v = $random(seed);
			wr(tjcfg_pkg::OFS_LINE_CODE, {27'h0, v[0], i[3:0]});
			@(posedge hclk);
			`CHK("line_code_q", exp_code(i[2:0], i[3]), line_code_q);
			`CHK("digital_if_q", i[3], digital_if_q);
			`CHK("single_rail_q", v[0], single_rail_q);
			rd(tjcfg_pkg::OFS_LINE_CODE, d);
			`CHK("line code readback", {v[0], i[3:0]}, d);
		end
		$display("test line codes done");

		for (i = 0; i < 8; i++) begin
			v = $random(seed);
			a = 8'h08 + {4'h0, 2'(v[9:8] % 3), 2'h0};
			a = (a == 8'h10) ? tjcfg_pkg::OFS_CLOCK_GEN : a;
			wr(a, {24'h0, v[7:0]});
			rd(a, d);
			`CHK("random readback", v[7:0], d);
		end
		wr(tjcfg_pkg::OFS_CLOCK_GEN, 32'h00000000);
		rd(8'h40, d);
		wr(8'h44, 32'h00000000);
		wr(tjcfg_pkg::OFS_COMMAND, 32'h00000001);
		rd(tjcfg_pkg::OFS_COMMAND, d);
		`CHK("command reads", 32'h00000000, d);
		$display("test registers done");

		// Basic set-up completed before any line traffic
		wr(tjcfg_pkg::OFS_MODE, 32'h00000001);
		wr(tjcfg_pkg::OFS_LINE_CODE, 32'h00000002);
		wr(tjcfg_pkg::OFS_LOS_DETECT, 32'h0000000a);
		wr(tjcfg_pkg::OFS_LOS_RECOVERY, 32'h00000015);
		line(1'b0, 170);
		line(1'b1, 1);
		line(1'b0, 175);
		`CHK("los after mark", 1'b0, los_q);
		line(1'b0, 1);
		`CHK("los at 176 zeros", 1'b1, los_q);
		rd(tjcfg_pkg::OFS_STATUS, d);
		`CHK("status los", 32'h00000001, d);
		`CHK("irq masked", 0, irq_cnt);
		$display("test detect done");

		wr(tjcfg_pkg::OFS_INT_MASK, 32'h00000000);
		line(1'b1, 21);
		`CHK("los at 21 ones", 1'b1, los_q);
		line(1'b1, 1);
		`CHK("los at 22 ones", 1'b0, los_q);
		`CHK("no clear irq", 0, irq_cnt);
		$display("test recovery done");

		// Optional features only once basic operation works
		wr(tjcfg_pkg::OFS_LOS_CTRL, 32'h00000003);
		wr(tjcfg_pkg::OFS_COMMAND, 32'h00000001);
		line(1'b0, 176);
		`CHK("los again", 1'b1, los_q);
		`CHK("set irq", 1, irq_cnt);
		line(1'b0, 15);
		line(1'b1, 22);
		`CHK("los after zero run", 1'b1, los_q);
		line(1'b1, 176);
		`CHK("los next window", 1'b0, los_q);
		`CHK("clear irq", 2, irq_cnt);
		$display("test density done");

		// Frozen clock enable: bits offered meanwhile are never counted
		ce <= 1'b0;
		line(1'b0, 176);
		ce <= 1'b1;
		@(posedge hclk);
		`CHK("los with ce low", 1'b0, los_q);
		line(1'b0, 176);
		`CHK("los after ce back", 1'b1, los_q);
		`CHK("set irq again", 3, irq_cnt);
		$display("test clock enable done");
		finish_test();
	end

	initial begin
		k = 0;
		while (k < 90000) begin
			@(posedge hclk);
			k++;
		end
		n_errors++;
		$display("CHECK FAILED run length expected end seen timeout");
		finish_test();
	end
endmodule : t1j1_init_config_los_tb

/* File: test/tjcfg_line_model.sv */
/*
 * Line-side partner: a T1/J1 receive bit source that strobes one bit at a
 * time into the block, slowly enough for its two-flop synchroniser.
 * Assumes hclk is the block's clock; strobe and data are asynchronous pins.
 */
`timescale 1ns/10ps
module tjcfg_line_model (
	input wire logic hclk,
	output logic line_bit_stb,
	output logic line_mark
);
	initial begin
		line_bit_stb = 1'b0;
		line_mark = 1'b0;
	end

	// ------------------------------------------------------------
	// Bit sender
	// ------------------------------------------------------------
	// Data is set two cycles before the strobe rises and held until two
	// cycles after it falls; afterwards the line shows the inverse so a
	// stale level can never pass for a received bit.
	task automatic send(input logic b, input int n);
		repeat (n) begin
			@(posedge hclk);
			line_mark <= b;
			repeat (2) @(posedge hclk);
			line_bit_stb <= 1'b1;
			repeat (3) @(posedge hclk);
			line_bit_stb <= 1'b0;
			repeat (2) @(posedge hclk);
			line_mark <= ~b;
		end
	endtask : send
endmodule : tjcfg_line_model
